// ===== tsc_timers.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tsc_timers
  import tsc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              extIrq0PinN,
  input  wire logic              extIrq1PinN,
  input  wire logic              count0Pin,
  input  wire logic              count1Pin,
  input  wire logic              timer2TriggerPin,
  input  wire logic              clockOutPinIn,
  output logic                   clockOutPinOut,
  output logic                   clockOutPinOe,
  output logic                   timer0Irq,
  output logic                   timer1Irq,
  output logic                   timer2Irq,
  output logic                   rxBaudTick,
  output logic                   txBaudTick
);
  typedef struct packed {
    logic [7:0]  mode01;
    logic [7:0]  ctrl01;
    logic [7:0]  ctrl2;
    logic [7:0]  xmode2;
    logic [7:0]  cfg;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] reload;
    logic [3:0]  pre;
    logic        half;
    logic        gate0On;
    logic        gate1On;
    logic        clkOut;
    logic        clkOe;
    logic        rxBaud;
    logic        txBaud;
    logic        irq2;
    logic [31:0] rdata;
  } tsc_state_t;
  tsc_state_t s;
  tsc_state_t next_s;

  logic              wrPulse;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0]        wrData;
  logic              rdPulse;
  logic [ADDR_W-1:0] rdAddr;
  logic [PIN_NUM-1:0] pinLevel;
  logic [PIN_NUM-1:0] pinFall;
  logic              mcTick;
  logic              fastTick;
  logic              run0;
  logic              run1;
  logic              run2;
  logic              ov0;
  logic              ov1;
  logic              ovHi0;
  logic              ov2;
  logic              trig2;
  logic              baud;
  logic              clkMode;
  logic [16:0]       step;
  logic [7:0]        rdByte;

  // ****************************************
  // bus slave and pin synchronisers
  // ****************************************
  tsc_axil_slave u_bus (
    .clk_sys (clk_sys),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata[7:0]),
    .wstrb0  (wstrb[0]),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrPulse (wrPulse),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .rdPulse (rdPulse),
    .rdAddr  (rdAddr)
  );

  tsc_pin_sync #(.WIDTH(PIN_NUM)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   ({clockOutPinIn, timer2TriggerPin, count1Pin, count0Pin, extIrq1PinN, extIrq0PinN}),
    .level   (pinLevel),
    .fall    (pinFall)
  );

  // ****************************************
  // counting step shared by timers 0 and 1
  // ****************************************
  // result is {overflow, new count}; split mode steps only the low byte
  function automatic logic [16:0] stepCnt(input logic [1:0] mode, input logic [15:0] c);
    logic [16:0] r;
    r = {1'b0, c};
    case (mode)
      MODE_13: begin
        r[4:0] = c[4:0] + 5'h01;
        if (c[4:0] == 5'h1F) begin
          r[15:8] = c[15:8] + 8'h01;
          r[16] = (c[15:8] == 8'hFF);
        end
      end
      MODE_16: r = {1'b0, c} + 17'h00001;
      MODE_AR8: begin
        r[7:0] = (c[7:0] == 8'hFF) ? c[15:8] : c[7:0] + 8'h01;
        r[16] = (c[7:0] == 8'hFF);
      end
      default: begin
        r[7:0] = c[7:0] + 8'h01;
        r[16] = (c[7:0] == 8'hFF);
      end
    endcase
    return r;
  endfunction

  // ****************************************
  // timer core
  // ****************************************
  always_comb begin
    next_s = s;
    step = '0;
    ov0 = 1'b0;
    ov1 = 1'b0;
    ovHi0 = 1'b0;
    rdByte = RST_BYTE;
    // machine cycle prescaler, 12 or 6 clocks
    mcTick = (s.pre == 4'h0);
    if (mcTick) begin
      next_s.pre = (s.cfg[BIT_DBL] ? MC_CLKS_DBL : MC_CLKS_STD) - 4'h1;
    end else begin
      next_s.pre = s.pre - 4'h1;
    end
    // fast rate gives n = 2 at 12 clocks and n = 1 at 6 clocks
    next_s.half = ~s.half;
    fastTick = s.cfg[BIT_DBL] | s.half;
    // timer 0: gate flips on a pin fall only while its run bit is set
    if (s.mode01[BIT_GATE] && s.ctrl01[BIT_TR0] && pinFall[PIN_IRQ0]) begin
      next_s.gate0On = ~s.gate0On;
    end
    run0 = s.ctrl01[BIT_TR0] && (!s.mode01[BIT_GATE] || s.gate0On)
           && (s.mode01[BIT_CT] ? pinFall[PIN_CNT0] : mcTick);
    if (run0) begin
      step = stepCnt(s.mode01[1:0], s.cnt0);
      next_s.cnt0 = step[15:0];
      ov0 = step[16];
    end
    // split mode: high byte of timer 0 borrows timer 1 run bit and flag
    if (s.mode01[1:0] == MODE_SPLIT && s.ctrl01[BIT_TR1] && mcTick) begin
      next_s.cnt0[15:8] = s.cnt0[15:8] + 8'h01;
      ovHi0 = (s.cnt0[15:8] == 8'hFF);
    end
    // timer 1: mode 3 holds it still
    if (s.mode01[BIT_GATE+4] && s.ctrl01[BIT_TR1] && pinFall[PIN_IRQ1]) begin
      next_s.gate1On = ~s.gate1On;
    end
    run1 = s.ctrl01[BIT_TR1] && (!s.mode01[BIT_GATE+4] || s.gate1On)
           && (s.mode01[5:4] != MODE_SPLIT)
           && (s.mode01[BIT_CT+4] ? pinFall[PIN_CNT1] : mcTick);
    if (run1) begin
      step = stepCnt(s.mode01[5:4], s.cnt1);
      next_s.cnt1 = step[15:0];
      ov1 = step[16] && (s.mode01[1:0] != MODE_SPLIT);
    end
    // timer 2 mode decode
    baud = s.ctrl2[BIT_RCLK] | s.ctrl2[BIT_TCLK];
    clkMode = s.xmode2[BIT_CLKOE] & ~s.ctrl2[BIT_CT2];
    run2 = s.ctrl2[BIT_TR2] && (s.ctrl2[BIT_CT2] ? pinFall[PIN_CNT2]
           : ((baud || clkMode) ? fastTick : mcTick));
    ov2 = run2 && (s.cnt2 == 16'hFFFF);
    trig2 = s.ctrl2[BIT_EXEN] && pinFall[PIN_TRIG];
    if (run2) begin
      // capture mode just wraps; reload and baud modes reload
      if (ov2 && (baud || !s.ctrl2[BIT_CAPT])) begin
        next_s.cnt2 = s.reload;
      end else begin
        next_s.cnt2 = s.cnt2 + 16'h0001;
      end
    end
    // pin trigger is ignored for reload and capture in baud mode
    if (trig2 && !baud) begin
      if (s.ctrl2[BIT_CAPT]) begin
        next_s.reload = s.cnt2;
      end else begin
        next_s.cnt2 = s.reload;
      end
    end
    // each roll-over flips the pin, so the duty cycle is exactly half
    if (ov2 && clkMode) begin
      next_s.clkOut = ~s.clkOut;
    end
    next_s.clkOe = clkMode;
    next_s.rxBaud = ov2 && s.ctrl2[BIT_RCLK];
    next_s.txBaud = ov2 && s.ctrl2[BIT_TCLK];
    // software writes override counting in the same cycle
    if (wrPulse) begin
      case (wrAddr)
        OFS_MODE01:    next_s.mode01 = wrData;
        OFS_CTRL01:    next_s.ctrl01 = wrData;
        OFS_CTRL2:     next_s.ctrl2 = wrData;
        OFS_XMODE2:    next_s.xmode2 = wrData;
        OFS_CNT0_LO:   next_s.cnt0[7:0] = wrData;
        OFS_CNT0_HI:   next_s.cnt0[15:8] = wrData;
        OFS_CNT1_LO:   next_s.cnt1[7:0] = wrData;
        OFS_CNT1_HI:   next_s.cnt1[15:8] = wrData;
        OFS_CNT2_LO:   next_s.cnt2[7:0] = wrData;
        OFS_CNT2_HI:   next_s.cnt2[15:8] = wrData;
        OFS_RELOAD_LO: next_s.reload[7:0] = wrData;
        OFS_RELOAD_HI: next_s.reload[15:8] = wrData;
        OFS_CONFIG:    next_s.cfg = wrData;
        default:       next_s.cfg = next_s.cfg;
      endcase
    end
    // flag sets come last so a set beats a clear in the same cycle
    if (ov0) next_s.ctrl01[BIT_TF0] = 1'b1;
    if (ov1 || ovHi0) next_s.ctrl01[BIT_TF1] = 1'b1;
    if (ov2 && !baud && !clkMode) next_s.ctrl2[BIT_TF2] = 1'b1;
    if (trig2) next_s.ctrl2[BIT_EXF2] = 1'b1;
    next_s.irq2 = next_s.ctrl2[BIT_TF2] | next_s.ctrl2[BIT_EXF2];
    // read data register
    case (rdAddr)
      OFS_MODE01:    rdByte = s.mode01;
      OFS_CTRL01:    rdByte = s.ctrl01;
      OFS_CTRL2:     rdByte = s.ctrl2;
      OFS_XMODE2:    rdByte = s.xmode2;
      OFS_CNT0_LO:   rdByte = s.cnt0[7:0];
      OFS_CNT0_HI:   rdByte = s.cnt0[15:8];
      OFS_CNT1_LO:   rdByte = s.cnt1[7:0];
      OFS_CNT1_HI:   rdByte = s.cnt1[15:8];
      OFS_CNT2_LO:   rdByte = s.cnt2[7:0];
      OFS_CNT2_HI:   rdByte = s.cnt2[15:8];
      OFS_RELOAD_LO: rdByte = s.reload[7:0];
      OFS_RELOAD_HI: rdByte = s.reload[15:8];
      OFS_CONFIG:    rdByte = s.cfg;
      default:       rdByte = RST_BYTE;
    endcase
    if (rdPulse) begin
      next_s.rdata = {24'h000000, rdByte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs, all straight from state
  // ****************************************
  assign rdata          = s.rdata;
  assign clockOutPinOut = s.clkOut;
  assign clockOutPinOe  = s.clkOe;
  assign timer0Irq      = s.ctrl01[BIT_TF0];
  assign timer1Irq      = s.ctrl01[BIT_TF1];
  assign timer2Irq      = s.irq2;
  assign rxBaudTick     = s.rxBaud;
  assign txBaudTick     = s.txBaud;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence gate1Fall;
    s.mode01[BIT_GATE+4] && s.ctrl01[BIT_TR1] && pinFall[PIN_IRQ1];
  endsequence
  sequence gate0Fall;
    s.mode01[BIT_GATE] && s.ctrl01[BIT_TR0] && pinFall[PIN_IRQ0];
  endsequence

  mc_period_a: assert property (mcTick && !s.cfg[BIT_DBL] |=> !mcTick [*8])
    else $error("machine cycle tick came early");
  run0_stop_a: assert property (!s.ctrl01[BIT_TR0] && !s.mode01[BIT_GATE] && !wrPulse
    && s.mode01[1:0] != MODE_SPLIT |=> s.cnt0 == $past(s.cnt0))
    else $error("timer 0 moved with run bit clear");
  run1_stop_a: assert property (!s.ctrl01[BIT_TR1] && !wrPulse |=> s.cnt1 == $past(s.cnt1))
    else $error("timer 1 moved with run bit clear");
  mode3_hold_a: assert property (s.mode01[5:4] == MODE_SPLIT && !wrPulse |=> $stable(s.cnt1))
    else $error("timer 1 ran in mode 3");
  gate1_flip_a: assert property (gate1Fall |=> s.gate1On != $past(s.gate1On))
    else $error("timer 1 gate did not toggle");
  gate0_flip_a: assert property (gate0Fall |=> s.gate0On != $past(s.gate0On))
    else $error("timer 0 gate did not toggle");
  ovf0_flag_a: assert property (run0 && s.mode01[1:0] == MODE_16 && s.cnt0 == 16'hFFFF
    |=> timer0Irq && s.cnt0 == 16'h0000 || $past(wrPulse))
    else $error("timer 0 overflow lost");
  reload2_a: assert property (ov2 && !s.ctrl2[BIT_CAPT] && !trig2 && !wrPulse
    |=> s.cnt2 == $past(s.reload))
    else $error("timer 2 did not reload");
  capture2_a: assert property (trig2 && !baud && s.ctrl2[BIT_CAPT] && !wrPulse
    |=> s.reload == $past(s.cnt2))
    else $error("timer 2 did not capture");
  clkout_flip_a: assert property (ov2 && clkMode |=> clockOutPinOut != $past(clockOutPinOut))
    else $error("clock out did not toggle");
  clkout_noflag_a: assert property (ov2 && clkMode && !s.ctrl2[BIT_TF2] && !wrPulse
    |=> !s.ctrl2[BIT_TF2])
    else $error("clock out roll-over raised a flag");
  baud_tick_a: assert property (ov2 && s.ctrl2[BIT_RCLK] |=> rxBaudTick ##1 (!rxBaudTick || $past(ov2)))
    else $error("receive baud tick missing");
endmodule

// ===== tsc_pkg.sv
package tsc_pkg;
  // ****************************************
  // register map, byte addresses on the bus
  // ****************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE01    = 8'h00;
  localparam logic [7:0]  OFS_CTRL01    = 8'h04;
  localparam logic [7:0]  OFS_CTRL2     = 8'h08;
  localparam logic [7:0]  OFS_XMODE2    = 8'h0C;
  localparam logic [7:0]  OFS_CNT0_LO   = 8'h10;
  localparam logic [7:0]  OFS_CNT0_HI   = 8'h14;
  localparam logic [7:0]  OFS_CNT1_LO   = 8'h18;
  localparam logic [7:0]  OFS_CNT1_HI   = 8'h1C;
  localparam logic [7:0]  OFS_CNT2_LO   = 8'h20;
  localparam logic [7:0]  OFS_CNT2_HI   = 8'h24;
  localparam logic [7:0]  OFS_RELOAD_LO = 8'h28;
  localparam logic [7:0]  OFS_RELOAD_HI = 8'h2C;
  localparam logic [7:0]  OFS_CONFIG    = 8'h30;
  localparam logic [7:0]  OFS_LAST      = 8'h30;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_GATE = 3;
  localparam int BIT_CT   = 2;
  localparam int BIT_TF1  = 7;
  localparam int BIT_TR1  = 6;
  localparam int BIT_TF0  = 5;
  localparam int BIT_TR0  = 4;
  localparam int BIT_TF2  = 7;
  localparam int BIT_EXF2 = 6;
  localparam int BIT_RCLK = 5;
  localparam int BIT_TCLK = 4;
  localparam int BIT_EXEN = 3;
  localparam int BIT_TR2  = 2;
  localparam int BIT_CT2  = 1;
  localparam int BIT_CAPT = 0;
  localparam int BIT_CLKOE = 1;
  localparam int BIT_DBL  = 0;
  // pin order on the synchroniser vector
  localparam int PIN_IRQ0 = 0;
  localparam int PIN_IRQ1 = 1;
  localparam int PIN_CNT0 = 2;
  localparam int PIN_CNT1 = 3;
  localparam int PIN_TRIG = 4;
  localparam int PIN_CNT2 = 5;
  localparam int PIN_NUM  = 6;
  // ****************************************
  // modes, reset values and counts
  // ****************************************
  localparam logic [1:0]  MODE_13    = 2'h0;
  localparam logic [1:0]  MODE_16    = 2'h1;
  localparam logic [1:0]  MODE_AR8   = 2'h2;
  localparam logic [1:0]  MODE_SPLIT = 2'h3;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [3:0]  MC_CLKS_STD = 4'hC;
  localparam logic [3:0]  MC_CLKS_DBL = 4'h6;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ===== tsc_pin_sync.sv
`timescale 1ns/1ps
module tsc_pin_sync
  import tsc_pkg::*;
#(
  parameter int WIDTH = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] fall;
  } tsc_sync_t;
  tsc_sync_t s;
  tsc_sync_t next_s;
  logic [WIDTH-1:0] agree;

  // a level counts only once stages two and three agree
  always_comb begin
    next_s = s;
    agree = ~(s.s2 ^ s.s3);
    next_s.s1 = pinIn;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.level = (agree & s.s2) | (~agree & s.level);
    next_s.fall = s.level & agree & ~s.s2;
  end

  // level resets low so release never fakes a falling edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign fall  = s.fall;
endmodule

// ===== tsc_axil_slave.sv
`timescale 1ns/1ps
module tsc_axil_slave
  import tsc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        wdata,
  input  wire logic              wstrb0,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wrPulse,
  output logic [ADDR_W-1:0]      wrAddr,
  output logic [7:0]             wrData,
  output logic                   rdPulse,
  output logic [ADDR_W-1:0]      rdAddr
);
  typedef struct packed {
    logic              awReady;
    logic              wReady;
    logic              awGot;
    logic              wGot;
    logic              strb;
    logic [ADDR_W-1:0] wAddr;
    logic [7:0]        wData;
    logic              wrPulse;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic [ADDR_W-1:0] rAddr;
    logic              rdPulse;
    logic              rValid;
    logic [1:0]        rResp;
  } tsc_axil_t;
  tsc_axil_t s;
  tsc_axil_t next_s;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a[1:0] == 2'h0) && (a <= OFS_LAST);
  endfunction

  // address and data may arrive in either order; one of each at a time
  always_comb begin
    next_s = s;
    next_s.wrPulse = 1'b0;
    next_s.rdPulse = 1'b0;
    if (awvalid && s.awReady) begin
      next_s.awGot = 1'b1;
      next_s.awReady = 1'b0;
      next_s.wAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wGot = 1'b1;
      next_s.wReady = 1'b0;
      next_s.wData = wdata;
      next_s.strb = wstrb0;
    end
    // only a mapped address with the low lane enabled stores anything
    if (s.awGot && s.wGot) begin
      next_s.awGot = 1'b0;
      next_s.wGot = 1'b0;
      next_s.wrPulse = hit(s.wAddr) && s.strb;
      next_s.bValid = 1'b1;
      next_s.bResp = hit(s.wAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
      next_s.awReady = 1'b1;
      next_s.wReady = 1'b1;
    end
    // read data register in the core is loaded on the same edge as rvalid
    if (arvalid && s.arReady) begin
      next_s.arReady = 1'b0;
      next_s.rdPulse = 1'b1;
      next_s.rAddr = araddr;
    end
    if (s.rdPulse) begin
      next_s.rValid = 1'b1;
      next_s.rResp = hit(s.rAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
      next_s.arReady = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awReady;
  assign wready  = s.wReady;
  assign bvalid  = s.bValid;
  assign bresp   = s.bResp;
  assign arready = s.arReady;
  assign rvalid  = s.rValid;
  assign rresp   = s.rResp;
  assign wrPulse = s.wrPulse;
  assign wrAddr  = s.wAddr;
  assign wrData  = s.wData;
  assign rdPulse = s.rdPulse;
  assign rdAddr  = s.rAddr;
endmodule

// ===== tb_tsc_timers.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_tsc_timers
  import tsc_pkg::*;
;
  logic        clk_sys = 1'h0, rst = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, v, w, g;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, clockOutPinOut, clockOutPinOe;
  logic        timer0Irq, timer1Irq, timer2Irq, rxBaudTick, txBaudTick;
  logic [1:0]  bresp, rresp, rs;
  logic [5:0]  pins = 6'h3F;
  logic [7:0]  baud[3] = '{8'h34, 8'h24, 8'h14};
  int          n_mismatch = 0, comparisons = 0, seed = 62, d, k, rc, tc;

  tsc_timers dut_u (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .extIrq0PinN(pins[PIN_IRQ0]), .extIrq1PinN(pins[PIN_IRQ1]), .count0Pin(pins[PIN_CNT0]),
    .count1Pin(pins[PIN_CNT1]), .timer2TriggerPin(pins[PIN_TRIG]), .clockOutPinIn(pins[PIN_CNT2]),
    .clockOutPinOut, .clockOutPinOe, .timer0Irq, .timer1Irq, .timer2Irq, .rxBaudTick, .txBaudTick);

  // free-running system clock
  initial forever #5 clk_sys = ~clk_sys;

  // ****************************************
  // bus and pin tasks
  // ****************************************
  task automatic summarize(input bit to);
    if (to) n_mismatch++;
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    bit ga = 0, gw = 0, gb = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, dv};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 40 && !gb; i++) begin
      @(posedge clk_sys);
      if (ga && gw && bvalid) begin
        gb = 1;
        bready <= 1'h0;
      end
      if (awready && !ga) begin
        ga = 1;
        awvalid <= 1'h0;
      end
      if (wready && !gw) begin
        gw = 1;
        wvalid <= 1'h0;
      end
    end
    if (!gb) summarize(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dv, output logic [1:0] r);
    bit gr = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 40 && !gr; i++) begin
      @(posedge clk_sys);
      if (rvalid) begin
        gr = 1;
        rready <= 1'h0;
        dv = rdata[7:0];
        r = rresp;
      end
      if (arready && arvalid) arvalid <= 1'h0;
    end
    if (!gr) summarize(1);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    logic [1:0] r;
    rd(a, x, r);
    `CHK(nm, e, x)
  endtask

  // pulses wide enough to pass the three-stage synchroniser
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pins[p] <= 1'h0;
      repeat (8) @(posedge clk_sys);
      pins[p] <= 1'h1;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  // skips the first, possibly partial, level and counts one full level
  task automatic halfper(output int n);
    logic o;
    n = 0;
    @(posedge clk_sys);
    o = clockOutPinOut;
    while (clockOutPinOut === o && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    o = clockOutPinOut;
    n = 0;
    while (clockOutPinOut === o && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    for (int a = 0; a <= 48; a += 4) rchk("reset", a[7:0], 8'h00);
    rd(8'h34, v, rs);
    `CHK("unmapped", RESP_SLVERR, rs)
    v = 8'($random(seed));
    w = 8'($random(seed));
    wr(OFS_CNT2_LO, v);
    wr(OFS_CNT2_HI, w);
    rchk("cnt2lo", OFS_CNT2_LO, v);
    rchk("cnt2hi", OFS_CNT2_HI, w);
    // timer 0 from zero, timer 1 eight cycles short of overflow
    wr(OFS_CNT1_HI, 8'hFF);
    wr(OFS_CNT1_LO, 8'hF8);
    wr(OFS_MODE01, 8'h11);
    wr(OFS_CTRL01, 8'h50);
    repeat (240) @(posedge clk_sys);
    `CHK("t1flag", 1'h1, timer1Irq)
    `CHK("t0flag", 1'h0, timer0Irq)
    wr(OFS_CTRL01, 8'h00);
    rd(OFS_CNT0_LO, v, rs);
    `CHK("t0rate", 1'h1, v >= 8'h13 && v <= 8'h15)
    rd(OFS_CNT1_LO, w, rs);
    `CHK("t1wrap", 1'h1, w >= 8'h0B && w <= 8'h0D)
    rchk("t1hi", OFS_CNT1_HI, 8'h00);
    `CHK("t1clr", 1'h0, timer1Irq)
    repeat (50) @(posedge clk_sys);
    rchk("t0stop", OFS_CNT0_LO, v);
    // timer 1 in mode 3 holds still while its run bit is set
    wr(OFS_MODE01, 8'h31);
    wr(OFS_CTRL01, 8'h50);
    repeat (60) @(posedge clk_sys);
    rchk("t1mode3", OFS_CNT1_LO, w);
    wr(OFS_CTRL01, 8'h10);
    repeat (60) @(posedge clk_sys);
    rchk("t1stop", OFS_CNT1_LO, w);
    // pin-gated timer 0 idles until a fall on its irq pin
    wr(OFS_MODE01, 8'h09);
    wr(OFS_CNT0_LO, 8'h00);
    repeat (60) @(posedge clk_sys);
    rchk("gateoff", OFS_CNT0_LO, 8'h00);
    pulse(PIN_IRQ0, 1);
    repeat (60) @(posedge clk_sys);
    rd(OFS_CNT0_LO, v, rs);
    `CHK("gateon", 1'h1, v != 8'h00)
    wr(OFS_MODE01, 8'h05);
    wr(OFS_CNT0_LO, 8'h00);
    pulse(PIN_CNT0, 5);
    rchk("events", OFS_CNT0_LO, 8'h05);
    // clock out with a random short reload distance
    d = 1 + ($unsigned($random(seed)) % 8);
    wr(OFS_CNT2_HI, 8'hFF);
    wr(OFS_CNT2_LO, 8'hFF);
    wr(OFS_RELOAD_HI, 8'hFF);
    wr(OFS_RELOAD_LO, 8'(256 - d));
    wr(OFS_XMODE2, 8'h02);
    wr(OFS_CTRL2, 8'h04);
    halfper(k);
    `CHK("half12", 2 * d, k)
    `CHK("oe", 1'h1, clockOutPinOe)
    `CHK("noflag", 1'h0, timer2Irq)
    wr(OFS_CONFIG, 8'h01);
    halfper(k);
    `CHK("half6", d, k)
    foreach (baud[i]) begin
      wr(OFS_CTRL2, baud[i]);
      rc = 0;
      tc = 0;
      repeat (200) begin
        @(posedge clk_sys);
        rc += rxBaudTick;
        tc += txBaudTick;
      end
      `CHK("rx", baud[i][5], rc > 0)
      `CHK("tx", baud[i][4], tc > 0)
    end
    // both baud directions with the clock pin still driven by internal counting
    wr(OFS_CTRL2, 8'h34);
    halfper(k);
    `CHK("both", d, k)
    `CHK("baudflag", 1'h0, timer2Irq)
    // trigger fall captures the running count into the reload pair
    wr(OFS_CTRL2, 8'h00);
    wr(OFS_XMODE2, 8'h00);
    wr(OFS_CNT2_HI, 8'h00);
    wr(OFS_CNT2_LO, 8'h00);
    wr(OFS_CTRL2, 8'h0D);
    pulse(PIN_TRIG, 1);
    `CHK("trigflag", 1'h1, timer2Irq)
    rchk("capture", OFS_RELOAD_HI, 8'h00);
    summarize(0);
  end
endmodule
